// ===== hw/asrtp_pkg.sv
// Purpose: constants for the asynchronous static memory port controller
// Assumes: system clock of 100 MHz, one cycle is 10 ns
// Notes:   times in ns, cycle counts derived from them
package asrtp_pkg;
  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam int DATA_W = 4;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int RD_ACCESS_NS  = 12;  // read cycle, also access time
  localparam int OE_ACCESS_NS  = 6;   // output enable to valid
  localparam int RELEASE_NS    = 6;   // any release to high impedance
  localparam int ADDR_END_NS   = 8;   // address valid to write end
  localparam int SEL_END_NS    = 8;   // select to write end
  localparam int PULSE_NS      = 8;   // write pulse
  localparam int WR_CYCLE_NS   = 12;  // write cycle
  localparam int DATA_SETUP_NS = 6;   // data before write end
  localparam int WR_OFF_NS     = 3;   // write off to output low-z
  // least times round up, at least one cycle
  function automatic int min_cycles(input int t_ns);
    int c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int RD_CYC       = min_cycles(RD_ACCESS_NS) + 1;  // one extra for sample margin
  localparam int HZ_CYC       = min_cycles(RELEASE_NS);
  localparam int PULSE_CYC    = (min_cycles(PULSE_NS) > min_cycles(DATA_SETUP_NS)) ?
                                min_cycles(PULSE_NS) : min_cycles(DATA_SETUP_NS);
  localparam int WR_CYCLE_CYC = min_cycles(WR_CYCLE_NS);
  localparam int RECOVER_CYC  = min_cycles(WR_OFF_NS);
  localparam int CNT_W   = 4;
  // ---------------------------------------------------------------
  // reset values of the pins
  // ---------------------------------------------------------------
  localparam logic STROBE_IDLE = 1'h1;
endpackage

// ===== hw/asrtp_timer.sv
// Purpose: down counter that times each pin phase
// Assumes: load and count on the same clock enable
// Notes:   done is high while the count is zero
`timescale 1ns/1ps
module asrtp_timer #(
  parameter int CNT_W = 4
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             clk_en,
  // control
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_val,
  // status
  output logic                  done
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  // next count: load wins, else count down to zero
  assign cnt_nxt = load ? load_val :
                   (cnt_r != {CNT_W{1'b0}}) ? cnt_r - {{(CNT_W-1){1'b0}}, 1'b1} : cnt_r;
  assign done    = (cnt_r == {CNT_W{1'b0}});

  // counter register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= {CNT_W{1'b0}};
    end else if (clk_en) begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// ===== hw/asrtp_sync.sv
// Purpose: two flip-flop synchroniser for the data pins read back
// Assumes: data pins change outside the clock domain
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module asrtp_sync #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         clk_en,
  // data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] d_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  assign d_out = sync_r;

  // two stage capture
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else if (clk_en) begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end
endmodule

// ===== hw/asrtp_ctrl.sv
// Purpose: controller driving an asynchronous 1M x 4 static memory
// Assumes: one request at a time; memory obeys its access times
// Notes:   writes are write-enable controlled, output enable stays high
// Functional notes
// - keep a strobe high whenever the address changes
// - address valid no later than select falling
// - never drive the data pins while select and output enable are low
// - read data valid within 12 ns; read cycles last at least 12 ns
// - address valid 8 ns before write end, write cycle 12 ns
// - select low at least 8 ns before write end
// - write pulse lasts at least 8 ns
// - address set up 0 ns before the later strobe falls
// - address held 0 ns after the earlier strobe rises
// - write data valid at least 6 ns before write end
// - write data held until write end, 0 ns after
`timescale 1ns/1ps
module asrtp_ctrl #(
  parameter int ADDR_W = asrtp_pkg::ADDR_W,
  parameter int DATA_W = asrtp_pkg::DATA_W
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              clk_en,
  // user request
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  // user answer
  output logic                   rsp_valid,
  output logic      [DATA_W-1:0] rsp_rdata,
  // memory pins
  output logic                   mem_cs_n,
  output logic                   mem_oe_n,
  output logic                   mem_we_n,
  output logic      [ADDR_W-1:0] word_address,
  output logic      [DATA_W-1:0] data_pins_o,
  output logic                   data_pins_oe,
  input  wire logic [DATA_W-1:0] data_pins_i
);
  localparam int CNT_W = asrtp_pkg::CNT_W;

  // ---------------------------------------------------------------
  // state and registers
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_ACC,
    ST_RD_SYNC,
    ST_RD_OFF,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_END
  } asrtp_state_type;

  asrtp_state_type   state_r;
  asrtp_state_type   state_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] rdata_r;
  logic              rsp_valid_r;
  logic              cs_n_r;
  logic              oe_n_r;
  logic              we_n_r;
  logic              drv_r;
  logic              cs_n_nxt;
  logic              oe_n_nxt;
  logic              we_n_nxt;
  logic              drv_nxt;
  logic              tmr_load;
  logic [CNT_W-1:0]  tmr_val;
  logic              tmr_done;
  logic [DATA_W-1:0] rd_sync;
  logic [CNT_W-1:0]  sync_cnt_r;
  logic              take;
  logic              rd_done;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [CNT_W-1:0] cyc(input int n);
    return CNT_W'(n - 1);
  endfunction

  asrtp_timer #(
    .CNT_W (CNT_W)
  ) u_timer (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .clk_en   (clk_en),
    .load     (tmr_load),
    .load_val (tmr_val),
    .done     (tmr_done)
  );

  asrtp_sync #(
    .W (DATA_W)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clk_en  (clk_en),
    .d_in    (data_pins_i),
    .d_out   (rd_sync)
  );

  // ---------------------------------------------------------------
  // decoding
  // ---------------------------------------------------------------
  // request accepted only when idle
  assign req_ready = (state_r == ST_IDLE);
  assign take      = req_valid && req_ready;
  // synchroniser delay covered once two more cycles have passed
  assign rd_done   = (sync_cnt_r == CNT_W'(2));

  // outputs from flip-flops
  assign mem_cs_n     = cs_n_r;
  assign mem_oe_n     = oe_n_r;
  assign mem_we_n     = we_n_r;
  assign word_address = addr_r;
  assign data_pins_o  = wdata_r;
  assign data_pins_oe = drv_r;
  assign rsp_valid    = rsp_valid_r;
  assign rsp_rdata    = rdata_r;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // next state and pin levels
  always_comb begin
    state_nxt = state_r;
    cs_n_nxt  = cs_n_r;
    oe_n_nxt  = oe_n_r;
    we_n_nxt  = we_n_r;
    drv_nxt   = drv_r;
    tmr_load  = 1'b0;
    tmr_val   = {CNT_W{1'b0}};
    case (state_r)
      ST_IDLE: begin
        cs_n_nxt = asrtp_pkg::STROBE_IDLE;
        if (take && !req_write) begin
          cs_n_nxt  = 1'b0;
          oe_n_nxt  = 1'b0;
          tmr_load  = 1'b1;
          tmr_val   = cyc(asrtp_pkg::RD_CYC);
          state_nxt = ST_RD_ACC;
        end else if (take) begin
          tmr_load  = 1'b1;
          tmr_val   = cyc(1);
          state_nxt = ST_WR_SETUP;
        end
      end
      ST_RD_ACC: begin
        if (tmr_done) begin
          state_nxt = ST_RD_SYNC;
        end
      end
      ST_RD_SYNC: begin
        if (rd_done) begin
          cs_n_nxt  = 1'b1;
          oe_n_nxt  = 1'b1;
          tmr_load  = 1'b1;
          tmr_val   = cyc(asrtp_pkg::HZ_CYC);
          state_nxt = ST_RD_OFF;
        end
      end
      ST_RD_OFF: begin
        if (tmr_done) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_WR_SETUP: begin
        if (tmr_done) begin
          cs_n_nxt  = 1'b0;
          we_n_nxt  = 1'b0;
          oe_n_nxt  = 1'b1;
          tmr_load  = 1'b1;
          tmr_val   = cyc(asrtp_pkg::HZ_CYC);
          state_nxt = ST_WR_PULSE;
        end
      end
      ST_WR_PULSE: begin
        drv_nxt = 1'b1;
        if (tmr_done && drv_r) begin
          tmr_load  = 1'b1;
          tmr_val   = cyc(asrtp_pkg::PULSE_CYC);
          state_nxt = ST_WR_END;
        end
      end
      ST_WR_END: begin
        if (tmr_done) begin
          cs_n_nxt  = 1'b1;
          we_n_nxt  = 1'b1;
          tmr_load  = 1'b1;
          tmr_val   = cyc(asrtp_pkg::RECOVER_CYC);
          state_nxt = ST_RD_OFF;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // state and strobes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cs_n_r  <= 1'b1;
      oe_n_r  <= 1'b1;
      we_n_r  <= 1'b1;
    end else if (clk_en) begin
      state_r <= state_nxt;
      cs_n_r  <= cs_n_nxt;
      oe_n_r  <= oe_n_nxt;
      we_n_r  <= we_n_nxt;
    end
  end

  // data driver: off as soon as the write ends
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      drv_r <= 1'b0;
    end else if (clk_en) begin
      drv_r <= drv_nxt && (state_nxt == ST_WR_PULSE || state_nxt == ST_WR_END);
    end
  end

  // address and write data latched on acceptance
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr_r  <= {ADDR_W{1'b0}};
      wdata_r <= {DATA_W{1'b0}};
    end else if (clk_en && take) begin
      addr_r  <= req_addr;
      wdata_r <= req_wdata;
    end
  end

  // synchroniser latency counter
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync_cnt_r <= {CNT_W{1'b0}};
    end else if (clk_en) begin
      sync_cnt_r <= (state_r == ST_RD_SYNC) ? sync_cnt_r + CNT_W'(1) : {CNT_W{1'b0}};
    end
  end

  // read answer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rsp_valid_r <= 1'b0;
      rdata_r     <= {DATA_W{1'b0}};
    end else if (clk_en) begin
      rsp_valid_r <= (state_r == ST_RD_SYNC) && rd_done;
      if ((state_r == ST_RD_SYNC) && rd_done) begin
        rdata_r <= rd_sync;
      end
    end
  end
endmodule

// ===== verif/asrtp_ctrl_chk.sv
// Purpose: pin protocol checks on the memory controller
// Assumes: one clock, async active-high reset
// Notes:   bound to every controller instance
`timescale 1ns/1ps
module asrtp_ctrl_chk #(
  parameter int ADDR_W = 20,
  parameter int DATA_W = 4
) (
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              rst,
  // memory pins and answer
  input wire logic              mem_cs_n,
  input wire logic              mem_oe_n,
  input wire logic              mem_we_n,
  input wire logic [ADDR_W-1:0] word_address,
  input wire logic [DATA_W-1:0] data_pins_o,
  input wire logic              data_pins_oe,
  input wire logic              rsp_valid
);
  // ---------------------------------------------------------------
  // pin protocol
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // address moves only with a strobe up before and after
  addr_move_a: assert property (!$stable(word_address) |->
    (mem_cs_n || mem_we_n) && ($past(mem_cs_n) || $past(mem_we_n)))
    else $error("address moved during write overlap");
  // no drive while memory may drive
  no_fight_a: assert property (!mem_cs_n && !mem_oe_n |-> !data_pins_oe)
    else $error("data driven while memory outputs on");
  // output enable kept off in writes
  oe_in_wr_a: assert property (!mem_we_n |-> mem_oe_n)
    else $error("output enable low in write");
  // drive starts a cycle after write enable fell
  late_drive_a: assert property ($rose(data_pins_oe) |-> !mem_we_n && !$past(mem_we_n))
    else $error("data driven before memory off");
  // write overlap lasts at least two cycles
  pulse_len_a: assert property ($fell(mem_we_n) |-> !mem_cs_n ##1 !mem_cs_n && !mem_we_n)
    else $error("write pulse too short");
  // data driven a full cycle before write end
  data_setup_a: assert property ($rose(mem_we_n) |-> $past(data_pins_oe))
    else $error("write data late");
  // data steady until write end
  data_hold_a: assert property (!mem_we_n && $past(data_pins_oe) |->
    data_pins_oe && $stable(data_pins_o))
    else $error("write data changed in pulse");
  // read select lasts two cycles or more
  read_len_a: assert property ($fell(mem_oe_n) |-> (!mem_oe_n && !mem_cs_n)[*2])
    else $error("read cycle too short");
  // address settled before the write strobes fall
  addr_setup_a: assert property ($fell(mem_we_n) |-> $stable(word_address))
    else $error("address moved as write began");
  // main scenarios
  cov_wr: cover property ($rose(mem_we_n));
  cov_rd: cover property ($fell(mem_oe_n));
  cov_rsp: cover property (rsp_valid);
endmodule
bind asrtp_ctrl asrtp_ctrl_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .mem_cs_n(mem_cs_n), .mem_oe_n(mem_oe_n),
  .mem_we_n(mem_we_n), .word_address(word_address), .data_pins_o(data_pins_o),
  .data_pins_oe(data_pins_oe), .rsp_valid(rsp_valid));

// ===== verif/asrtp_mem_model.sv
// Purpose: behavioural static memory, 1M words by 4 bits
// Assumes: pins come from the controller under test
// Notes:   released lines show the inverse of the word
`timescale 1ns/1ps
module asrtp_mem_model #(
  parameter int ACC_NS = 12
) (
  // strobes and address
  input wire logic        cs_n,
  input wire logic        oe_n,
  input wire logic        we_n,
  input wire logic [19:0] addr,
  // data lines
  input wire logic [3:0]  din,
  output logic     [3:0]  q,
  output logic            q_en
);
  // ---------------------------------------------------------------
  // storage and outputs
  // ---------------------------------------------------------------
  logic [3:0] mem_arr [0:1048575];
  logic [3:0] rd_q;
  logic [3:0] din_d;
  wire        wr_on = !cs_n && !we_n;
  wire        rd_on = !cs_n && !oe_n && we_n;
  assign #1 din_d = din;
  always @(negedge wr_on) begin
    mem_arr[addr] = din_d;
  end
  assign #(ACC_NS) rd_q = mem_arr[addr];
  assign #3 q_en = rd_on;
  assign q = q_en ? rd_q : ~rd_q;
endmodule

// ===== verif/tb_async_sram_timing_port.sv
// Purpose: self-checking bench for the static memory controller
// Assumes: behavioural memory on the pins
// Notes:   inputs change at the falling edge
`timescale 1ns/1ps
module tb_async_sram_timing_port;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic        clk_sys;
  logic        rst;
  logic        clk_en;
  logic        req_valid;
  logic        req_write;
  logic [19:0] req_addr;
  logic [3:0]  req_wdata;
  logic        req_ready;
  logic        rsp_valid;
  logic [3:0]  rsp_rdata;
  logic        mem_cs_n;
  logic        mem_oe_n;
  logic        mem_we_n;
  logic [19:0] word_address;
  logic [3:0]  data_pins_o;
  logic        data_pins_oe;
  logic [3:0]  mem_q;
  logic        mem_q_en;
  wire  [3:0]  pins_bus = data_pins_oe ? data_pins_o : mem_q;
  wire  [3:0]  pin_set = {mem_cs_n, mem_oe_n, mem_we_n, data_pins_oe};
  int          err_total;
  int          num_checks;
  asrtp_ctrl DUT (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .mem_cs_n(mem_cs_n), .mem_oe_n(mem_oe_n),
    .mem_we_n(mem_we_n), .word_address(word_address), .data_pins_o(data_pins_o),
    .data_pins_oe(data_pins_oe), .data_pins_i(pins_bus));
  asrtp_mem_model #(.ACC_NS(12)) u_mem (.cs_n(mem_cs_n), .oe_n(mem_oe_n),
    .we_n(mem_we_n), .addr(word_address), .din(pins_bus), .q(mem_q), .q_en(mem_q_en));
  // free-running clock
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask
  task automatic hang();
    err_total++;
    give_verdict();
  endtask
  // one request, held until taken, then its answer
  task automatic xfer(input logic wr, input logic [19:0] a, input logic [3:0] d,
                      output logic [3:0] q);
    int   n;
    logic seen;
    n = 0;
    seen = wr;
    q = 4'hX;
    @(negedge clk_sys);
    req_valid = 1'h1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    while (!(req_ready === 1'h1 && clk_en === 1'h1)) begin
      @(negedge clk_sys);
      n++;
      if (n > 30) hang();
    end
    @(negedge clk_sys);
    req_valid = 1'h0;
    while (!(req_ready === 1'h1 && seen)) begin
      if (rsp_valid === 1'h1) begin
        q = rsp_rdata;
        seen = 1'h1;
      end
      @(negedge clk_sys);
      chk("drive clash", 4'h0, {3'h0, mem_q_en & data_pins_oe});
      n++;
      if (n > 60) hang();
    end
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // edge and pattern addresses written, read back, then address 0 overwritten
  task automatic s_rw();
    logic [19:0] a [4] = '{20'h00000, 20'hFFFFF, 20'h5A5A5, 20'hA5A5A};
    logic [3:0]  q;
    foreach (a[i]) xfer(1'h1, a[i], 4'(i * 5 + 3), q);
    foreach (a[i]) begin
      xfer(1'h0, a[i], 4'h0, q);
      chk("read back", 4'(i * 5 + 3), q);
    end
    xfer(1'h1, a[0], 4'hF, q);
    xfer(1'h0, a[0], 4'h0, q);
    chk("overwrite", 4'hF, q);
  endtask
  // clock enable dropped in mid write
  task automatic s_freeze();
    logic [3:0] q;
    logic [3:0] pins;
    fork
      xfer(1'h1, 20'h12345, 4'h6, q);
      begin
        repeat (4) @(negedge clk_sys);
        clk_en = 1'h0;
        pins = pin_set;
        repeat (5) @(negedge clk_sys);
        chk("frozen pins", pins, pin_set);
        clk_en = 1'h1;
      end
    join
    xfer(1'h0, 20'h12345, 4'h0, q);
    chk("read after freeze", 4'h6, q);
  endtask
  // reset in mid write, other words kept
  task automatic s_reset();
    logic [3:0] q;
    fork
      xfer(1'h1, 20'h00000, 4'hC, q);
      begin
        repeat (3) @(negedge clk_sys);
        rst = 1'h1;
        @(negedge clk_sys);
        chk("pins in reset", 4'hE, pin_set);
        repeat (11) @(negedge clk_sys);
        rst = 1'h0;
      end
    join
    xfer(1'h0, 20'hFFFFF, 4'h0, q);
    chk("read after reset", 4'h8, q);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    err_total = 0;
    num_checks = 0;
    rst = 1'h1;
    clk_en = 1'h1;
    req_valid = 1'h0;
    req_write = 1'h0;
    req_addr = 20'h00000;
    req_wdata = 4'h0;
    repeat (12) @(negedge clk_sys);
    rst = 1'h0;
    chk("idle pins", 4'hE, pin_set);
    s_rw();
    s_freeze();
    s_reset();
    give_verdict();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    hang();
  end
endmodule
